// ---- core/umes_pkg.sv ----
// constants, register map and field types for the serial mode/error block
// assumes a 50 MHz pclk and an APB master with 32-bit data
package umes_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_MODE = 16'hFFA0;
	localparam logic [15:0] IDX_ERR = 16'hFFA1;
	localparam logic [15:0] IDX_BAUD = 16'hFFA2;
	localparam logic [15:0] IDX_TXDATA = 16'hFFA3;
	localparam logic [15:0] IDX_RXBUF = 16'hFFA4;
	localparam logic [15:0] IDX_LINE = 16'hFFA5;
	localparam logic [31:0] ADDR_MODE = {14'h0000, IDX_MODE, 2'h0};
	localparam logic [31:0] ADDR_ERR = {14'h0000, IDX_ERR, 2'h0};
	localparam logic [31:0] ADDR_BAUD = {14'h0000, IDX_BAUD, 2'h0};
	localparam logic [31:0] ADDR_TXDATA = {14'h0000, IDX_TXDATA, 2'h0};
	localparam logic [31:0] ADDR_RXBUF = {14'h0000, IDX_RXBUF, 2'h0};
	localparam logic [31:0] ADDR_LINE = {14'h0000, IDX_LINE, 2'h0};
	// reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] ERR_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [7:0] RXBUF_RST = 8'h00;
	localparam logic [7:0] TXDATA_RST = 8'h00;
	// writable bit masks
	localparam logic [7:0] MODE_WMASK = 8'hFE;
	localparam logic [7:0] BAUD_WMASK = 8'h7F;
	// error status bit positions
	localparam int unsigned ERR_PARITY_BIT = 2;
	localparam int unsigned ERR_FRAMING_BIT = 1;
	localparam int unsigned ERR_OVERRUN_BIT = 0;
	// parity codes
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	// baud divider: prescaler n in 1..7, divisor k+16 with k in 0..14
	localparam logic [2:0] PRESC_PROHIBITED = 3'h0;
	localparam logic [3:0] DIV_PROHIBITED = 4'hF;
	localparam int unsigned CHAR_BITS_SHORT = 7;
	localparam int unsigned CHAR_BITS_LONG = 8;

	typedef struct packed {
		logic transmit_enable_bit;
		logic receive_enable_bit;
		logic parity_select_high;
		logic parity_select_low;
		logic char_length_select;
		logic stop_length_select;
		logic error_irq_suppress;
		logic fixed_zero;
	} umes_mode_t;

	typedef struct packed {
		logic fixed_zero;
		logic [2:0] prescaler_select;
		logic [3:0] divisor_select;
	} umes_baud_t;

	typedef struct packed {
		logic [4:0] fixed_zero;
		logic parity_error_flag;
		logic framing_error_flag;
		logic overrun_error_flag;
	} umes_err_t;
endpackage

// ---- core/umes_core.sv ----
// serial transceiver with mode, error status and baud divider registers
// assumes an APB master on pclk and a remote serial device on the pins;
// pin inputs are already synchronous to pclk
`timescale 1ns/1ps

// Behaviour
// - both enables off: idle, pins to port
// - bits 7/6 enable transmit and receive
// - start bit, then 7 or 8 bits
// - parity field: none, zero, odd, even
// - zero parity mode never flags parity error
// - stop length bit: one or two stops
// - receiver checks first stop bit only
// - suppress bit withholds completion on error
// - status bit 2 flags parity mismatch
// - status bit 1 flags missing stop bit
// - status bit 0 flags overrun
// - each unread completion raises overrun again
// - status read-only, high bits zero, reset 00
// - mode byte-writable, bit 0 zero, reset 00
// - generator reaches 31.25 kbps
// - bit rate fx over 2^(n+1)(k+16)
module umes_core
	import umes_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	input wire logic serial_input_line,
	output logic serial_output_line,
	output logic serial_input_sel,
	output logic serial_output_sel,
	// general port hand-back
	input wire logic port_line_twentyone_latch,
	output logic port_line_twentyone_out,
	// event requests
	output logic rx_complete_req,
	output logic tx_complete_req
);
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} umes_rx_t;
	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} umes_tx_t;
	umes_mode_t mode_q;
	umes_baud_t baud_q;
	umes_err_t err_q;
	umes_rx_t rx_state_q;
	umes_tx_t tx_state_q;
	logic [7:0] rxbuf_q;
	logic rxbuf_full_q;
	logic [31:0] prdata_q;
	logic [6:0] pre_cnt_q;
	logic [5:0] rx_cnt_q;
	logic [5:0] tx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [2:0] tx_bit_q;
	logic [7:0] rx_shift_q;
	logic [7:0] tx_shift_q;
	logic [7:0] tx_char_q;
	logic tx_stop2_q;
	logic rx_prev_q;
	logic tx_line_q;
	logic port21_q;
	logic rx_par_q;
	logic acc;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic gen_ok;
	logic fsck_en;
	logic [6:0] pre_top;
	logic [4:0] half_top;
	logic [5:0] full_top;
	logic [5:0] rx_top;
	logic rx_tick;
	logic tx_tick;
	logic [2:0] last_bit;
	logic par_on;
	logic rx_done;
	logic [7:0] rx_char;
	logic exp_par;
	logic rx_pe;
	logic fe_now;
	logic ov_now;
	logic tx_load;
	logic rxbuf_read;

	// parity bit for a character under the selected mode
	function automatic logic par_of(input logic [1:0] m,
		input logic [7:0] c);
		par_of = 1'b0;
		if (m == PAR_ODD) begin
			par_of = ~(^c);
		end else if (m == PAR_EVEN) begin
			par_of = ^c;
		end
	endfunction
	// bus decode; zero wait states, read data captured in the setup cycle
	assign acc = psel && penable;
	assign hit = (paddr == ADDR_MODE) || (paddr == ADDR_ERR) ||
		(paddr == ADDR_BAUD) || (paddr == ADDR_TXDATA) ||
		(paddr == ADDR_RXBUF) || (paddr == ADDR_LINE);
	assign pready = acc;
	assign pslverr = acc && !hit;
	assign wr_en = acc && pwrite && hit && pstrb[0];
	assign rd_en = acc && !pwrite;
	assign prdata = prdata_q;
	assign rxbuf_read = rd_en && (paddr == ADDR_RXBUF);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ADDR_MODE: prdata_q <= {24'h000000, mode_q};
				ADDR_ERR: prdata_q <= {24'h000000, err_q};
				ADDR_BAUD: prdata_q <= {24'h000000, baud_q};
				ADDR_TXDATA: prdata_q <= {24'h000000, tx_char_q};
				ADDR_RXBUF: prdata_q <= {24'h000000, rxbuf_q};
				ADDR_LINE: prdata_q <= {29'h0000_0000, rxbuf_full_q,
					~rx_state_q[0], ~tx_state_q[0]};
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end
	// mode register; bit 0 never stores a one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= umes_mode_t'(MODE_RST);
		end else if (wr_en && paddr == ADDR_MODE) begin
			mode_q <= umes_mode_t'(pwdata[7:0] & MODE_WMASK);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_q <= umes_baud_t'(BAUD_RST);
		end else if (wr_en && paddr == ADDR_BAUD) begin
			baud_q <= umes_baud_t'(pwdata[7:0] & BAUD_WMASK);
		end
	end
	// pin functions follow the enables
	assign serial_input_sel = mode_q.receive_enable_bit;
	assign serial_output_sel = mode_q.transmit_enable_bit;
	assign serial_output_line = tx_line_q;
	assign port_line_twentyone_out = port21_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port21_q <= 1'b0;
		end else if (mode_q.transmit_enable_bit) begin
			port21_q <= tx_line_q;
		end else begin
			port21_q <= port_line_twentyone_latch;
		end
	end
	// baud generator: fx / 2^n, then k+16 per half bit
	assign gen_ok = (baud_q.prescaler_select != PRESC_PROHIBITED) &&
		(baud_q.divisor_select != DIV_PROHIBITED);
	assign pre_top = 7'((8'h01 << baud_q.prescaler_select) - 8'h01);
	assign half_top = {1'b1, baud_q.divisor_select};
	assign full_top = {half_top, 1'b0};
	assign fsck_en = gen_ok && (pre_cnt_q == pre_top);
	// idle while both enables are off, saving the divider's toggling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt_q <= 7'h00;
		end else if (!gen_ok || fsck_en ||
			!(mode_q.transmit_enable_bit || mode_q.receive_enable_bit)) begin
			pre_cnt_q <= 7'h00;
		end else begin
			pre_cnt_q <= pre_cnt_q + 7'h01;
		end
	end
	assign last_bit = mode_q.char_length_select ?
		3'(CHAR_BITS_LONG - 1) : 3'(CHAR_BITS_SHORT - 1);
	assign par_on = mode_q.parity_select_high || mode_q.parity_select_low;
	// receiver
	assign rx_top = (rx_state_q == RX_START) ? {1'b0, half_top} : full_top;
	assign rx_tick = fsck_en && (rx_cnt_q == rx_top - 6'h01);
	assign rx_done = (rx_state_q == RX_STOP) && rx_tick &&
		mode_q.receive_enable_bit;
	assign rx_char = mode_q.char_length_select ? rx_shift_q :
		{1'b0, rx_shift_q[7:1]};
	assign exp_par = par_of({mode_q.parity_select_high,
		mode_q.parity_select_low}, rx_char);
	// zero parity is never checked
	assign rx_pe = mode_q.parity_select_high &&
		(exp_par != rx_par_q);
	assign fe_now = !serial_input_line;
	assign ov_now = rxbuf_full_q && !rxbuf_read;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev_q <= 1'b1;
		end else begin
			rx_prev_q <= serial_input_line;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q <= 6'h00;
			rx_bit_q <= 3'h0;
			rx_shift_q <= 8'h00;
			rx_par_q <= 1'b0;
		end else if (!mode_q.receive_enable_bit) begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q <= 6'h00;
		end else begin
			if (fsck_en) begin
				rx_cnt_q <= rx_tick ? 6'h00 : rx_cnt_q + 6'h01;
			end
			case (rx_state_q)
				RX_IDLE: begin
					rx_cnt_q <= 6'h00;
					if (rx_prev_q && !serial_input_line) begin
						rx_state_q <= RX_START;
					end
				end
				RX_START: if (rx_tick) begin
					rx_bit_q <= 3'h0;
					// a glitch that is high at mid-bit is no start bit
					rx_state_q <= serial_input_line ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_tick) begin
					rx_shift_q <= {serial_input_line, rx_shift_q[7:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == last_bit) begin
						rx_state_q <= par_on ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (rx_tick) begin
					rx_par_q <= serial_input_line;
					rx_state_q <= RX_STOP;
				end
				RX_STOP: if (rx_tick) begin
					rx_state_q <= RX_IDLE;
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// status and buffer; a new completion wins over a buffer read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= umes_err_t'(ERR_RST);
			rxbuf_q <= RXBUF_RST;
			rxbuf_full_q <= 1'b0;
		end else if (rx_done) begin
			err_q.parity_error_flag <= rx_pe;
			err_q.framing_error_flag <= fe_now;
			err_q.overrun_error_flag <= ov_now;
			rxbuf_q <= rx_char;
			rxbuf_full_q <= 1'b1;
		end else if (rxbuf_read) begin
			rxbuf_full_q <= 1'b0;
			err_q.overrun_error_flag <= 1'b0;
		end
	end
	// completion request, withheld on error when suppression is set
	assign rx_complete_req = rx_done && !(mode_q.error_irq_suppress &&
		(rx_pe || fe_now || ov_now));
	// transmitter
	assign tx_tick = fsck_en && (tx_cnt_q == full_top - 6'h01);
	assign tx_load = wr_en && (paddr == ADDR_TXDATA) &&
		mode_q.transmit_enable_bit && (tx_state_q == TX_IDLE);
	assign tx_complete_req = (tx_state_q == TX_STOP) && tx_tick &&
		!tx_stop2_q && mode_q.transmit_enable_bit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_char_q <= TXDATA_RST;
		end else if (tx_load) begin
			tx_char_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state_q <= TX_IDLE;
			tx_cnt_q <= 6'h00;
			tx_bit_q <= 3'h0;
			tx_shift_q <= 8'h00;
			tx_stop2_q <= 1'b0;
			tx_line_q <= 1'b1;
		end else if (!mode_q.transmit_enable_bit) begin
			tx_state_q <= TX_IDLE;
			tx_line_q <= 1'b1;
		end else begin
			if (fsck_en) begin
				tx_cnt_q <= tx_tick ? 6'h00 : tx_cnt_q + 6'h01;
			end
			case (tx_state_q)
				TX_IDLE: begin
					tx_line_q <= 1'b1;
					tx_cnt_q <= 6'h00;
					if (tx_load) begin
						tx_shift_q <= mode_q.char_length_select ?
							pwdata[7:0] : {1'b0, pwdata[6:0]};
						tx_line_q <= 1'b0;
						tx_state_q <= TX_START;
					end
				end
				TX_START: if (tx_tick) begin
					tx_bit_q <= 3'h0;
					tx_line_q <= tx_shift_q[0];
					tx_state_q <= TX_DATA;
				end
				TX_DATA: if (tx_tick) begin
					tx_bit_q <= tx_bit_q + 3'h1;
					if (tx_bit_q == last_bit) begin
						tx_stop2_q <= mode_q.stop_length_select;
						if (par_on) begin
							tx_line_q <= par_of({mode_q.parity_select_high,
								mode_q.parity_select_low},
								tx_shift_q);
							tx_state_q <= TX_PAR;
						end else begin
							tx_line_q <= 1'b1;
							tx_state_q <= TX_STOP;
						end
					end else begin
						tx_line_q <= tx_shift_q[3'(tx_bit_q + 3'h1)];
					end
				end
				TX_PAR: if (tx_tick) begin
					tx_line_q <= 1'b1;
					tx_state_q <= TX_STOP;
				end
				TX_STOP: if (tx_tick) begin
					if (tx_stop2_q) begin
						tx_stop2_q <= 1'b0;
					end else begin
						tx_state_q <= TX_IDLE;
					end
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end
endmodule

// ---- verif/umes_remote.sv ----
// remote serial device on the far side of the pins
// assumes one bit lasts BIT_T pclk cycles
`timescale 1ns/1ps
module umes_remote #(
	parameter int BIT_T = 64
) (
	// clock
	input wire logic pclk,
	// serial lines
	input wire logic tx_line,
	output logic rx_line
);
	initial rx_line = 1'b1;
	// lsb first, then back to idle high
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			rx_line <= f[i];
			repeat (BIT_T) @(posedge pclk);
		end
		rx_line <= 1'b1;
	endtask
	// centre sampling absorbs a short first start bit
	task automatic grab(output logic [11:0] b, input int n);
		int w;
		b = '1;
		w = 0;
		while (tx_line !== 1'b0 && w < 4000) begin
			@(posedge pclk);
			w++;
		end
		// on timeout b stays all ones, so the start bit reads high
		if (w < 4000) begin
			repeat (BIT_T / 2) @(posedge pclk);
			for (int i = 0; i < n; i++) begin
				b[i] = tx_line;
				repeat (BIT_T) @(posedge pclk);
			end
		end
	endtask
endmodule

// ---- verif/umes_core_properties.sv ----
// port assertions for the serial mode/error block
// assumes binding onto umes_core; mode tracked from apb writes
`timescale 1ns/1ps
module umes_core_properties
	import umes_pkg::*;
(
	// clock, reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	// pins, requests
	input wire logic serial_output_line,
	input wire logic serial_input_sel,
	input wire logic serial_output_sel,
	input wire logic port_line_twentyone_latch,
	input wire logic port_line_twentyone_out,
	input wire logic rx_complete_req,
	input wire logic tx_complete_req
);
	logic [7:0] mode_q;
	logic acc, wr_mode, rd_mode, rd_err;
	assign acc = psel && penable;
	assign wr_mode = acc && pwrite && pstrb[0] && paddr == ADDR_MODE;
	assign rd_mode = acc && !pwrite && paddr == ADDR_MODE;
	assign rd_err = acc && !pwrite && paddr == ADDR_ERR;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_q <= MODE_RST;
		else if (wr_mode)
			mode_q <= pwdata[7:0] & MODE_WMASK;
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// an aborted frame may need a cycle to drain
	sequence tx_off3;
		!mode_q[7] [*3];
	endsequence
	a_sel_mode: assert property (
		{serial_output_sel, serial_input_sel} == mode_q[7:6])
		else $error("select mismatch");
	a_port_handback: assert property (
		port_line_twentyone_out == ($past(mode_q[7]) ?
		$past(serial_output_line) : $past(port_line_twentyone_latch)))
		else $error("port out mismatch");
	a_tx_idle_high: assert property (
		tx_off3 |-> serial_output_line) else $error("line not idle");
	a_mode_readback: assert property (
		rd_mode |-> prdata == {24'h000000, mode_q})
		else $error("mode read wrong");
	a_err_high_zero: assert property (
		rd_err |-> prdata[31:3] == '0) else $error("status high bits set");
	a_rx_gated: assert property (
		!mode_q[6] |-> !rx_complete_req) else $error("rx req while off");
	a_tx_gated: assert property (
		!mode_q[7] |-> !tx_complete_req) else $error("tx req while off");
	a_tx_done_stop: assert property (
		tx_complete_req |-> serial_output_line ##1 !tx_complete_req)
		else $error("tx end wrong");
endmodule
bind umes_core umes_core_properties u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .serial_output_line, .serial_input_sel, .serial_output_sel,
	.port_line_twentyone_latch, .port_line_twentyone_out,
	.rx_complete_req, .tx_complete_req
);

// ---- verif/testbench.sv ----
// self-checking bench for the serial mode/error block
// assumes umes_remote on the pins, apb from the tasks below
`timescale 1ns/1ps
module testbench;
	import umes_pkg::*;
	localparam int BIT_T = 64;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'h1;
	logic port_line_twentyone_latch = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, perr;
	logic serial_input_line, serial_output_line;
	logic serial_input_sel, serial_output_sel, port_line_twentyone_out;
	logic rx_complete_req, tx_complete_req;
	logic [11:0] bits;
	int errors = 0;
	int tests_run = 0;
	int pulses = 0;
	int tx_pulses = 0;
	umes_core dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .serial_input_line,
		.serial_output_line, .serial_input_sel, .serial_output_sel,
		.port_line_twentyone_latch, .port_line_twentyone_out,
		.rx_complete_req, .tx_complete_req
	);
	umes_remote #(.BIT_T(BIT_T)) remote (
		.pclk, .tx_line(serial_output_line), .rx_line(serial_input_line)
	);
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (rx_complete_req === 1'b1)
			pulses++;
		if (tx_complete_req === 1'b1)
			tx_pulses++;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20) begin
			errors++;
			stop_test;
		end
	endtask
	task automatic rdc(input logic [31:0] a, e);
		apb(1'b0, a, '0);
		chk(rd, e);
	endtask
	task automatic t_regs;
		rdc(ADDR_MODE, 32'h0);
		rdc(ADDR_ERR, 32'h0);
		apb(1'b1, ADDR_MODE, 32'hFF);
		rdc(ADDR_MODE, 32'hFE);
		chk({30'h0, serial_input_sel, serial_output_sel}, 32'h3);
		apb(1'b1, ADDR_ERR, 32'hFF);
		rdc(ADDR_ERR, 32'h0);
		apb(1'b0, 32'h100, '0);
		chk({31'h0, perr}, 32'h1);
		apb(1'b1, ADDR_MODE, 32'h0);
		port_line_twentyone_latch <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, port_line_twentyone_out}, 32'h1);
		port_line_twentyone_latch <= 1'b0;
		$display("regs done");
	endtask
	// stop length shows as busy still set at the second stop centre
	task automatic t_tx;
		logic [7:0] m[2] = '{8'hBC, 8'h90};
		logic [7:0] d[2] = '{8'hA5, 8'hFF};
		logic [11:0] e[2] = '{12'hD4A, 12'hEFE};
		int n[2] = '{11, 10};
		apb(1'b1, ADDR_BAUD, 32'h10);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, ADDR_MODE, {24'h0, m[i]});
			apb(1'b1, ADDR_TXDATA, {24'h0, d[i]});
			remote.grab(bits, n[i]);
			chk({20'h0, bits}, {20'h0, e[i]});
			if (bits[0] !== 1'b0)
				stop_test;
			apb(1'b0, ADDR_LINE, '0);
			chk(rd & 32'h1, (i == 0) ? 32'h1 : 32'h0);
			repeat (BIT_T) @(posedge pclk);
			chk(32'(tx_pulses), 32'(i + 1));
		end
		$display("transmit done");
	endtask
	task automatic rx_one(input logic [7:0] m, d, input logic p, s,
		input logic [7:0] e, input int q);
		int p0;
		apb(1'b1, ADDR_MODE, {24'h0, m});
		p0 = pulses;
		remote.send({s, p, d, 1'b0});
		rdc(ADDR_ERR, {24'h0, e});
		chk(32'(pulses - p0), 32'(q));
	endtask
	task automatic t_rx;
		rx_one(8'h68, 8'h3C, 1'b1, 1'b1, 8'h00, 1);
		rdc(ADDR_RXBUF, 32'h3C);
		rx_one(8'h6A, 8'h3C, 1'b0, 1'b1, 8'h04, 0);
		apb(1'b0, ADDR_RXBUF, '0);
		rx_one(8'h68, 8'h3C, 1'b1, 1'b0, 8'h02, 1);
		apb(1'b0, ADDR_RXBUF, '0);
		rx_one(8'h68, 8'h11, 1'b1, 1'b1, 8'h00, 1);
		rx_one(8'h68, 8'h22, 1'b1, 1'b1, 8'h01, 1);
		rx_one(8'h68, 8'h33, 1'b1, 1'b1, 8'h01, 1);
		rdc(ADDR_RXBUF, 32'h33);
		rx_one(8'h68, 8'h44, 1'b1, 1'b1, 8'h00, 1);
		rdc(ADDR_RXBUF, 32'h44);
		rx_one(8'h58, 8'h3C, 1'b1, 1'b1, 8'h00, 1);
		rdc(ADDR_RXBUF, 32'h3C);
		rx_one(8'h40, 8'h95, 1'b1, 1'b1, 8'h00, 1);
		rdc(ADDR_RXBUF, 32'h15);
		rx_one(8'h78, 8'h3C, 1'b1, 1'b1, 8'h04, 1);
		$display("receive done");
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_tx;
		t_rx;
		stop_test;
	end
endmodule
